/* cpd_cfg.svh */
// constants of the configuration front end: offsets, fields, timing
//
// Summary of operation
// - with compression on, incoming stream is expanded live and written to cell memory
// - decompression is never active while secure loading is enabled
// - decompression only in active serial and passive serial schemes
// - expander finishes each token before the next compressed byte arrives
// - compression is a per-device setting, independent of other chained devices
// - reset is held until the monitored supplies are stable
// - status pin driven low until all required supplies pass the trip point and the reset hold ends
// - core and analog supplies are watched for brownout after power-up
// - fast reset hold lasts more than 3 ms and less than 9 ms
// - standard reset hold lasts more than 50 ms and less than 200 ms
// - fast or standard hold is picked from the scheme select pins
// - active serial, active parallel, passive serial each have fast and standard codes
// - fast passive parallel exists only with the fast hold
// - boundary scan overrides the scheme, hold still follows the pins
// - during reset hold, status and load complete low, user pins high impedance
// - device stays in reset while config request or status line is low
`ifndef CPD_CFG_SVH
`define CPD_CFG_SVH

`define CPD_CLK_KHZ 50000
`define CPD_FAST_HOLD_MS 6
`define CPD_STD_HOLD_MS 100
`define CPD_HOLD_CNT_W 23

`define CPD_IDX_CTRL 6'h00
`define CPD_IDX_LEN 6'h01
`define CPD_IDX_STATUS 6'h02
`define CPD_IDX_IRQ_STAT 6'h03
`define CPD_IDX_IRQ_CLR 6'h04
`define CPD_IDX_IRQ_EN 6'h05

`define CPD_IRQ_W 4
`define CPD_IRQ_POR 0
`define CPD_IRQ_BROWN 1
`define CPD_IRQ_DONE 2
`define CPD_IRQ_REFUSE 3

`define CPD_LEN_W 24
`define CPD_TOK_RUN_BIT 7
`define CPD_RUN_W 3
`define CPD_BIT_LAST 3'h7

`endif

/* cpd_loader.sv */
// power-on reset sequencer and configuration stream expander
`include "cpd_cfg.svh"
`default_nettype none
module cpd_loader
  import cpd_pkg::*;
#(
  parameter int unsigned FAST_HOLD_CYC = `CPD_FAST_HOLD_MS * `CPD_CLK_KHZ,
  parameter int unsigned STD_HOLD_CYC = `CPD_STD_HOLD_MS * `CPD_CLK_KHZ
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  // supply monitors
  input wire logic core_supply_ok_i,
  input wire logic analog_supply_ok_i,
  input wire logic io_supply_ok_i,
  // scheme selection
  input wire logic [3:0] scheme_select_pins_i,
  input wire logic jtag_config_i,
  // configuration request and open-drain pins
  input wire logic config_req_n_i,
  input wire logic status_n_i,
  output logic status_n_o,
  output logic status_oe_n_o,
  input wire logic load_complete_i,
  output logic load_complete_o,
  output logic load_complete_oe_n_o,
  output logic user_io_hiz_o,
  // configuration stream in
  input wire logic stream_strobe_i,
  input wire logic stream_bit_i,
  // cell memory write port
  output logic cram_we_o,
  output logic [7:0] cram_data_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cpd_state_t state_reg, state_next;
  logic [`CPD_HOLD_CNT_W-1:0] hold_cnt_reg;
  logic fast_reg;
  cpd_ctrl_t ctrl_reg;
  logic [`CPD_LEN_W-1:0] len_reg;
  logic [`CPD_LEN_W-1:0] count_reg;
  logic [`CPD_IRQ_W-1:0] irq_stat_reg, irq_en_reg, irq_set;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic expect_lit_reg;
  logic [`CPD_RUN_W:0] run_left_reg;
  cpd_cram_t cram_reg;

  // ----------------------------------------------------------------
  // supply and scheme decode
  // ----------------------------------------------------------------
  wire all_supply_ok = core_supply_ok_i & analog_supply_ok_i & io_supply_ok_i;
  wire brownout = ~(core_supply_ok_i & analog_supply_ok_i);
  wire sc_fast = (scheme_select_pins_i == SC_AS_FAST) | (scheme_select_pins_i == SC_AP_FAST)
               | (scheme_select_pins_i == SC_PS_FAST) | (scheme_select_pins_i == SC_FPP_FAST);
  wire sc_serial = (scheme_select_pins_i == SC_AS_STD) | (scheme_select_pins_i == SC_AS_FAST)
                 | (scheme_select_pins_i == SC_PS_STD) | (scheme_select_pins_i == SC_PS_FAST);
  wire [`CPD_HOLD_CNT_W-1:0] fast_lim = FAST_HOLD_CYC[`CPD_HOLD_CNT_W-1:0];
  wire [`CPD_HOLD_CNT_W-1:0] std_lim = STD_HOLD_CYC[`CPD_HOLD_CNT_W-1:0];
  wire [`CPD_HOLD_CNT_W-1:0] hold_lim = fast_reg ? fast_lim : std_lim;
  wire hold_end = (state_reg == ST_HOLD) & (hold_cnt_reg == hold_lim);
  wire reset_req = ~config_req_n_i | ~status_n_i;
  wire decomp_act = ctrl_reg.compress & ~ctrl_reg.secure & sc_serial & ~jtag_config_i;
  wire len_hit = (len_reg != '0) & (count_reg == len_reg);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_SUPPLY:
        if (all_supply_ok) state_next = ST_HOLD;
      ST_HOLD:
        if (~all_supply_ok) state_next = ST_SUPPLY;
        else if (hold_end) state_next = ST_RESET;
      ST_RESET:
        if (brownout) state_next = ST_SUPPLY;
        else if (~reset_req) state_next = ST_LOAD;
      ST_LOAD:
        if (brownout) state_next = ST_SUPPLY;
        else if (reset_req) state_next = ST_RESET;
        else if (len_hit) state_next = ST_DONE;
      ST_DONE:
        if (brownout) state_next = ST_SUPPLY;
        else if (reset_req) state_next = ST_RESET;
      default:
        state_next = ST_SUPPLY;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_SUPPLY;
      hold_cnt_reg <= '0;
      fast_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      hold_cnt_reg <= (state_reg == ST_HOLD) ? hold_cnt_reg + 1'b1 : '0;
      // pins sampled as hold starts; boundary scan does not alter the pick
      if (state_reg == ST_SUPPLY) fast_reg <= sc_fast;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  wire in_por = (state_reg == ST_SUPPLY) | (state_reg == ST_HOLD);
  assign status_n_o = 1'b0;
  assign status_oe_n_o = ~in_por;
  assign load_complete_o = 1'b0;
  assign load_complete_oe_n_o = (state_reg == ST_DONE);
  assign user_io_hiz_o = (state_reg != ST_DONE);

  // ----------------------------------------------------------------
  // stream assembly and expansion
  // ----------------------------------------------------------------
  wire loading = (state_reg == ST_LOAD);
  wire take_bit = loading & stream_strobe_i;
  wire byte_done = take_bit & (bit_cnt_reg == `CPD_BIT_LAST);
  wire [7:0] new_byte = {shift_reg[6:0], stream_bit_i};
  wire tok_run = new_byte[`CPD_TOK_RUN_BIT];
  wire emit_lit = byte_done & (~decomp_act | expect_lit_reg);
  wire emit_run0 = byte_done & decomp_act & ~expect_lit_reg & tok_run;
  wire emit_runn = loading & (run_left_reg != '0);
  wire emit = emit_lit | emit_run0 | emit_runn;

  always_ff @(posedge clk_i)
  begin
    if (rst_i | ~loading)
    begin
      shift_reg <= '0;
      bit_cnt_reg <= '0;
      expect_lit_reg <= 1'b0;
      run_left_reg <= '0;
    end
    else
    begin
      if (take_bit) shift_reg <= new_byte;
      if (take_bit) bit_cnt_reg <= bit_cnt_reg + 1'b1;
      if (emit_lit) expect_lit_reg <= 1'b0;
      else if (byte_done & decomp_act & ~tok_run) expect_lit_reg <= 1'b1;
      // first zero goes out with the token, so a run ends before the next byte
      if (emit_run0) run_left_reg <= {1'b0, new_byte[`CPD_RUN_W-1:0]};
      else if (emit_runn) run_left_reg <= run_left_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cram_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      cram_reg.we <= emit;
      cram_reg.data <= emit_lit ? new_byte : 8'h00;
      if (~loading) count_reg <= '0;
      else if (emit) count_reg <= count_reg + 1'b1;
    end
  end

  assign cram_we_o = cram_reg.we;
  assign cram_data_o = cram_reg.data;

  // ----------------------------------------------------------------
  // wishbone registers and interrupts
  // ----------------------------------------------------------------
  wire wb_hit = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire wb_wr = wb_hit & wb_we_i;
  wire [5:0] wb_idx = wb_adr_i[7:2];
  wire wr_ctrl = wb_wr & (wb_idx == `CPD_IDX_CTRL) & wb_sel_i[0];
  wire wr_len = wb_wr & (wb_idx == `CPD_IDX_LEN);
  wire wr_clr = wb_wr & (wb_idx == `CPD_IDX_IRQ_CLR) & wb_sel_i[0];
  wire wr_en = wb_wr & (wb_idx == `CPD_IDX_IRQ_EN) & wb_sel_i[0];
  wire refuse = wr_ctrl & wb_dat_i[0] & (wb_dat_i[1] | ~sc_serial | jtag_config_i);
  cpd_status_t status_word;
  assign status_word = '{rsv: '0, jtag: jtag_config_i, decomp: decomp_act,
                         scheme: scheme_select_pins_i, fast: fast_reg, state: state_reg};
  wire [31:0] rd_mux =
    (wb_idx == `CPD_IDX_CTRL) ? 32'(ctrl_reg) :
    (wb_idx == `CPD_IDX_LEN) ? 32'(len_reg) :
    (wb_idx == `CPD_IDX_STATUS) ? 32'(status_word) :
    (wb_idx == `CPD_IDX_IRQ_STAT) ? 32'(irq_stat_reg) :
    (wb_idx == `CPD_IDX_IRQ_EN) ? 32'(irq_en_reg) : 32'h0000_0000;

  always_comb
  begin
    irq_set = '0;
    irq_set[`CPD_IRQ_POR] = hold_end;
    irq_set[`CPD_IRQ_BROWN] = ~in_por & brownout;
    irq_set[`CPD_IRQ_DONE] = loading & len_hit;
    irq_set[`CPD_IRQ_REFUSE] = refuse;
  end

  wire [`CPD_IRQ_W-1:0] clr_mask = wr_clr ? wb_dat_i[`CPD_IRQ_W-1:0] : '0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= '0;
      len_reg <= '0;
      irq_stat_reg <= '0;
      irq_en_reg <= '0;
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      ack_reg <= wb_hit;
      rdata_reg <= (wb_hit & ~wb_we_i) ? rd_mux : 32'h0000_0000;
      // per-device choice, chained devices set their own
      if (wr_ctrl) ctrl_reg <= '{rsv: '0, secure: wb_dat_i[1], compress: wb_dat_i[0]};
      if (wr_len) len_reg <= wb_dat_i[`CPD_LEN_W-1:0];
      // set wins over clear
      irq_stat_reg <= (irq_stat_reg & ~clr_mask) | irq_set;
      if (wr_en) irq_en_reg <= wb_dat_i[`CPD_IRQ_W-1:0];
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign irq_o = |(irq_stat_reg & irq_en_reg);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_status_por_low: assert property (@(posedge clk_i) disable iff (rst_i)
    in_por |-> (!status_oe_n_o && !status_n_o && !load_complete_oe_n_o && user_io_hiz_o))
    else $error("status or user pins released during power-on hold");

  a_supply_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_SUPPLY && !all_supply_ok) |=> (state_reg == ST_SUPPLY))
    else $error("left supply wait without stable supplies");

  a_brownout_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    (!in_por && brownout) |=> (state_reg == ST_SUPPLY && !status_oe_n_o))
    else $error("brownout did not re-enter reset");

  a_hold_window: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(state_reg == ST_HOLD) && state_reg == ST_RESET) |->
      $past(hold_cnt_reg) == (fast_reg ? fast_lim : std_lim))
    else $error("reset hold ended at wrong count");

  a_hold_pick: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_SUPPLY && all_supply_ok) |=> (fast_reg == $past(sc_fast)))
    else $error("hold length not taken from scheme pins");

  a_reset_request: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_RESET && reset_req && !brownout) |=> (state_reg == ST_RESET))
    else $error("left reset while request or status low");

  a_secure_excl: assert property (@(posedge clk_i) disable iff (rst_i)
    decomp_act |-> (!ctrl_reg.secure && sc_serial && !jtag_config_i))
    else $error("decompression active in forbidden mode");

  a_no_stall: assert property (@(posedge clk_i) disable iff (rst_i)
    (run_left_reg != '0) |-> !byte_done)
    else $error("expander still busy when next byte arrived");

  a_run_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    emit_run0 |=> (cram_we_o && cram_data_o == 8'h00))
    else $error("run token did not write a zero byte");

  a_raw_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    (byte_done && !decomp_act) |=> (cram_we_o && cram_data_o == $past(new_byte)))
    else $error("uncompressed byte not written through");

  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_hold_early: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_HOLD && all_supply_ok && !hold_end) |=> (state_reg == ST_HOLD))
    else $error("reset hold ended before its count");

  a_pick_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg != ST_SUPPLY) |=> $stable(fast_reg))
    else $error("hold choice changed after supply wait");

  a_status_release: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_RESET || state_reg == ST_LOAD) |-> status_oe_n_o)
    else $error("status still driven after power-on hold");

  a_no_write_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg != ST_LOAD) |=> !cram_we_o)
    else $error("cell memory written outside loading");

  a_secure_block: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_ctrl && wb_dat_i[1]) |=> !decomp_act)
    else $error("decompression left on with secure loading");

  a_scheme_raw: assert property (@(posedge clk_i) disable iff (rst_i)
    (byte_done && !sc_serial) |=> (cram_we_o && cram_data_o == $past(new_byte)))
    else $error("parallel scheme byte not written through");

  a_literal_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (byte_done && expect_lit_reg) |=> (cram_we_o && cram_data_o == $past(new_byte)))
    else $error("literal byte not written");

  a_token_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (byte_done && decomp_act && !expect_lit_reg && !tok_run) |=> !cram_we_o)
    else $error("literal token wrote cell memory");

  a_run_drain: assert property (@(posedge clk_i) disable iff (rst_i)
    (loading && run_left_reg != '0) |=> (cram_we_o && cram_data_o == 8'h00))
    else $error("run expansion paused");

  a_done_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_LOAD && len_hit && !brownout && !reset_req) |=>
      (state_reg == ST_DONE && !user_io_hiz_o))
    else $error("load did not complete at length");

  a_brown_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (!in_por && brownout) |=> irq_stat_reg[`CPD_IRQ_BROWN])
    else $error("brownout event not flagged");

endmodule : cpd_loader
`default_nettype wire

/* cpd_loader_test.sv */
// self-checking bench of the configuration front end
`default_nettype none
module cpd_loader_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cpd_pkg::*;
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("MISMATCH %s exp %h got %h", nm, e, g); \
    end \
  end
  logic clk, rst, cyc, stb, we, irq, ack, core_ok, ana_ok, io_ok, jtag, cfg_n;
  logic stat_o, stat_oe_n, ldc_o, ldc_oe_n, hiz, strobe, sbit, cram_we;
  logic [7:0] adr, cram_d;
  logic [3:0] pins;
  logic [31:0] dat_w, dat_r, rd;
  logic [7:0] exp_q[$], got_q[$];
  int miscompares = 0, checked = 0, seed, lim;
  logic fs, dc;
  wire logic stat_n = stat_oe_n | stat_o;
  wire logic ldc_i = ldc_oe_n | ldc_o;
  // -------------------------------------------------
  // design and source
  // -------------------------------------------------
  cpd_loader #(.FAST_HOLD_CYC(20), .STD_HOLD_CYC(50)) u_dut (.clk_i(clk), .rst_i(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .irq_o(irq),
    .core_supply_ok_i(core_ok), .analog_supply_ok_i(ana_ok), .io_supply_ok_i(io_ok),
    .scheme_select_pins_i(pins), .jtag_config_i(jtag), .config_req_n_i(cfg_n),
    .status_n_i(stat_n), .status_n_o(stat_o), .status_oe_n_o(stat_oe_n),
    .load_complete_i(ldc_i), .load_complete_o(ldc_o), .load_complete_oe_n_o(ldc_oe_n),
    .user_io_hiz_o(hiz), .stream_strobe_i(strobe), .stream_bit_i(sbit),
    .cram_we_o(cram_we), .cram_data_o(cram_d));
  cpd_src u_src (.clk_i(clk), .strobe_o(strobe), .bit_o(sbit));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
    if (cram_we === 1'b1)
      got_q.push_back(cram_d);
  // -------------------------------------------------
  // tasks
  // -------------------------------------------------
  task end_sim;
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      miscompares++;
      end_sim;
    end
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic pwr_up(input logic [3:0] code, input logic j);
    int n;
    n = 0;
    fs = code inside {4'h1, 4'h3, 4'h5, 4'h6};
    dc = code inside {4'h0, 4'h1, 4'h4, 4'h5} && !j;
    lim = fs ? 20 : 50;
    pins <= code;
    jtag <= j;
    @(posedge clk);
    core_ok <= 1'b1;
    ana_ok <= 1'b1;
    io_ok <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end while (stat_oe_n !== 1'b1 && n < 400);
    `CHK("hold_len", 1'b1, n >= lim && n <= lim + 3)
    if (n >= 400)
      end_sim;
  endtask : pwr_up
  task automatic tx(input logic [7:0] b);
    u_src.send(b, $urandom_range(0, 2));
  endtask : tx
  task automatic cmp_q;
    repeat (12) @(posedge clk);
    `CHK("cram_cnt", exp_q.size(), got_q.size())
    foreach (exp_q[k])
      if (k < got_q.size())
        `CHK("cram_byte", exp_q[k], got_q[k])
    exp_q.delete();
    got_q.delete();
  endtask : cmp_q
  // -------------------------------------------------
  // main sequence
  // -------------------------------------------------
  initial
  begin
    logic [7:0] b;
    rst = 1'b1;
    {cyc, stb, we, core_ok, ana_ok, io_ok, jtag} = '0;
    adr = '0;
    dat_w = '0;
    pins = '0;
    cfg_n = 1'b1;
    seed = $urandom(32'h2664);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("rst_drv", 3'b001, {stat_oe_n, ldc_oe_n, hiz})
    for (int i = 0; i < 8; i++)
    begin
      pwr_up((i < 7) ? i[3:0] : 4'h5, i == 7);
      wb(1'b0, 8'h08, '0);
      `CHK("fast", {fs, 3'h2}, {rd[3], rd[2:0]})
      `CHK("hiz", 1'b1, hiz)
      wb(1'b1, 8'h00, 32'h1);
      wb(1'b0, 8'h08, '0);
      `CHK("decomp", dc, rd[8])
      b = 8'($urandom);
      if (dc)
      begin
        tx({5'h10, b[2:0]});
        repeat (b[2:0] + 1) exp_q.push_back(8'h00);
        tx(8'h00);
        tx(b);
        exp_q.push_back(b);
      end
      else
      begin
        tx(b);
        exp_q.push_back(b);
      end
      cmp_q();
      wb(1'b0, 8'h0c, '0);
      `CHK("refuse", !dc, rd[3])
      if (i[0])
        ana_ok <= 1'b0;
      else
        core_ok <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK("brown_pin", 1'b0, stat_oe_n)
      wb(1'b0, 8'h0c, '0);
      `CHK("brown_irq", 1'b1, rd[1])
      wb(1'b1, 8'h10, 32'hf);
      wb(1'b1, 8'h00, 32'h0);
    end
    pwr_up(4'h5, 1'b0);
    wb(1'b1, 8'h00, 32'h3);
    wb(1'b0, 8'h08, '0);
    `CHK("secure", 1'b0, rd[8])
    wb(1'b1, 8'h14, 32'h8);
    `CHK("irq_on", 1'b1, irq)
    wb(1'b1, 8'h10, 32'h8);
    @(posedge clk);
    `CHK("irq_off", 1'b0, irq)
    cfg_n <= 1'b0;
    wb(1'b0, 8'h08, '0);
    `CHK("req_low", 3'h3, rd[2:0])
    cfg_n <= 1'b1;
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h04, 32'h2);
    wb(1'b0, 8'h44, '0);
    `CHK("unmapped", 32'h0, rd)
    repeat (2)
    begin
      b = 8'($urandom);
      tx(b);
      exp_q.push_back(b);
    end
    cmp_q();
    wb(1'b0, 8'h08, '0);
    `CHK("done", {3'h6, 1'b0, 1'b1}, {rd[2:0], hiz, ldc_oe_n})
    end_sim;
  end
endmodule : cpd_loader_test
`default_nettype wire

/* cpd_pkg.sv */
// types of the configuration front end
`default_nettype none
package cpd_pkg;

  typedef enum logic [2:0] {
    ST_SUPPLY = 3'h0,
    ST_HOLD = 3'h1,
    ST_RESET = 3'h3,
    ST_LOAD = 3'h2,
    ST_DONE = 3'h6
  } cpd_state_t;

  typedef enum logic [3:0] {
    SC_AS_STD = 4'h0,
    SC_AS_FAST = 4'h1,
    SC_AP_STD = 4'h2,
    SC_AP_FAST = 4'h3,
    SC_PS_STD = 4'h4,
    SC_PS_FAST = 4'h5,
    SC_FPP_FAST = 4'h6
  } cpd_scheme_t;

  typedef struct packed {
    logic [29:0] rsv;
    logic secure;
    logic compress;
  } cpd_ctrl_t;

  typedef struct packed {
    logic [21:0] rsv;
    logic jtag;
    logic decomp;
    logic [3:0] scheme;
    logic fast;
    logic [2:0] state;
  } cpd_status_t;

  typedef struct packed {
    logic we;
    logic [7:0] data;
  } cpd_cram_t;

endpackage : cpd_pkg
`default_nettype wire

/* cpd_src.sv */
// serial configuration source that feeds the loader stream port
`default_nettype none
module cpd_src
(
  // clock
  input wire logic clk_i,
  // stream out
  output logic strobe_o,
  output logic bit_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    strobe_o = 1'b0;
    bit_o = 1'b0;
  end
  // -------------------------------------------------
  // byte sender, msb first, gap 0 keeps strobes back to back
  // -------------------------------------------------
  // bytes go out as given; compression is chosen per device in the loader control register
  task automatic send(input logic [7:0] b, input int gap);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge clk_i);
      strobe_o <= 1'b1;
      bit_o <= b[i];
      if (gap > 0)
      begin
        @(posedge clk_i);
        strobe_o <= 1'b0;
        bit_o <= ~b[i];
        repeat (gap - 1) @(posedge clk_i);
      end
    end
    // idle line shows the inverse of the last bit
    @(posedge clk_i);
    strobe_o <= 1'b0;
    bit_o <= ~b[0];
  endtask : send
endmodule : cpd_src
`default_nettype wire
